//--- verilog/dfl_pkg.sv
// Constants shared by the drive error-flag logic.
package dfl_pkg;
  // Register select codes on the control bus.
  localparam logic [4:0] SEL_CONTROL = 5'h00;
  localparam logic [4:0] SEL_STATUS = 5'h01;
  localparam logic [4:0] SEL_FAULT_ONE = 5'h02;
  localparam logic [4:0] SEL_MAINT = 5'h03;
  localparam logic [4:0] SEL_ATTN_SUMMARY = 5'h04;
  // Select codes that exist in the whole drive, one bit per code.
  localparam logic [31:0] SEL_EXIST_MASK = 32'h0000_FFFF;
  // Select codes that are read only.
  localparam logic [31:0] SEL_READONLY_MASK = 32'h0000_00C2;

  // Control register fields.
  localparam int CTL_GO_BIT = 0;
  localparam int CTL_FN_LSB = 1;
  localparam int CTL_FN_W = 5;
  localparam logic [4:0] FN_DRIVE_CLEAR = 5'h04;
  // Implemented function codes, one bit per code.
  localparam logic [31:0] FN_IMPL_MASK = 32'h3C3F_FFDF;

  // Status register fields.
  localparam int STS_COMPOSITE_BIT = 14;
  localparam int STS_ATTENTION_BIT = 15;

  // Fault register bit positions.
  localparam int FB_ILLEGAL_FUNCTION = 0;
  localparam int FB_BAD_REGISTER_SELECT = 1;
  localparam int FB_WRITE_REFUSED = 2;
  localparam int FB_ODD_CHECK_FAULT = 3;
  localparam int FB_PACK_FORMAT_MISMATCH = 4;
  localparam int FB_WRITE_CLOCK_MISSING = 5;
  localparam int FB_UNCORRECTABLE_ECC = 6;
  localparam int FB_HEADER_MISMATCH = 7;
  localparam int FB_HEADER_CHECK_FAULT = 8;
  localparam int FB_ADDRESS_OVERFLOW = 9;
  localparam int FB_INVALID_TARGET = 10;
  localparam int FB_WRITE_PROTECT_VIOLATION = 11;
  localparam int FB_TIMING_FAILURE = 12;
  localparam int FB_OPERATION_TIMEOUT = 13;
  localparam int FB_HAZARD_CONDITION = 14;
  localparam int FB_READ_ECC_FAULT = 15;
  localparam logic [15:0] FAULT_RESET = 16'h0000;

  // Header word bit compared against the offset register.
  localparam int HDR_FORMAT_BIT = 12;

  // Addressing limits.
  localparam logic [4:0] MAX_SECTOR_20 = 5'd19;
  localparam logic [4:0] MAX_SECTOR_22 = 5'd21;
  localparam logic [9:0] MAX_CYLINDER = 10'h19A;
  localparam logic [4:0] MAX_TRACK = 5'd18;

  // Index pulses without progress before an operation is declared stalled.
  localparam int STALL_INDEX_COUNT = 3;
endpackage

//--- verilog/dfl_sticky_bits.sv
// Sticky flag bits with clear priority, load and newly-set report.
module dfl_sticky_bits #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic [WIDTH-1:0] setBits,
  input wire logic clearAll,
  input wire logic load,
  input wire logic [WIDTH-1:0] loadValue,
  // State
  output logic [WIDTH-1:0] flags,
  output logic [WIDTH-1:0] rising
);
  logic [WIDTH-1:0] flags_reg;
  logic [WIDTH-1:0] flags_next;
  wire logic [WIDTH-1:0] baseValue = load ? loadValue : flags_reg;

  // A clear in the same cycle as an event wins, so a stale event cannot survive a drive clear.
  assign flags_next = clearAll ? RESET_VALUE : (baseValue | setBits);
  assign rising = flags_next & ~flags_reg;
  assign flags = flags_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= RESET_VALUE;
    end else begin
      flags_reg <= flags_next;
    end
  end
endmodule

//--- verilog/dfl_stall_watch.sv
// Counts index pulses while an operation makes no progress.
module dfl_stall_watch #(
  parameter int LIMIT = dfl_pkg::STALL_INDEX_COUNT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Operation tracking
  input wire logic arm,
  input wire logic progress,
  input wire logic abandon,
  input wire logic positioning,
  input wire logic indexPulse,
  // Result
  output logic expired
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  generate
    if (LIMIT < 1) begin : gBad
      $error("dfl_stall_watch: LIMIT must be at least one");
    end
  endgenerate

  logic armed_reg;
  logic [CW-1:0] count_reg;
  logic expired_reg;
  // Only index pulses seen while the heads stand still are counted.
  wire logic countNow = armed_reg && indexPulse && !positioning;
  wire logic hitLimit = countNow && (count_reg + ONE_C == LIMIT_C);
  wire logic stopNow = progress || abandon || hitLimit;

  assign expired = expired_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      armed_reg <= 1'b0;
      count_reg <= '0;
      expired_reg <= 1'b0;
    end else begin
      expired_reg <= hitLimit && !progress && !abandon;
      if (stopNow) begin
        armed_reg <= 1'b0;
        count_reg <= '0;
      end else if (arm) begin
        armed_reg <= 1'b1;
        count_reg <= '0;
      end else if (countNow) begin
        count_reg <= count_reg + ONE_C;
      end
    end
  end
endmodule

//--- verilog/dfl_fault_flags.sv
// Drive error register, attention flag and exception handling.
// What this block does
// - Drive clear, attention summary one-write or bus init clears attention.
// - Switching out of the neutral selection position raises no attention.
// - Fault register is writable; any bit rising sets composite error.
// - Unimplemented function code written to control sets bit 0.
// - Nonexistent register select sets bit 1; read-only writes ignored silently.
// - Writes during an operation except maintenance/summary refused, set bit 2.
// - Write data parity fault sets bit 3 and exception; data still accepted.
// - At end-of-block fall, run high continues, run low terminates with attention.
// - Exception released at trailing edge of end-of-block pulse.
// - Control bus parity fault during register write sets parity bit.
// - Header format bit mismatch sets bit 4, aborts except read header.
// - Missing write clock during write sets bit 5 and aborts.
// - Uncorrectable result of correction sets bit 6.
// - Header address mismatch bit 7, check fault bit 8; block transfer except read header.
// - Run still high after last sector sets bit 9 and terminates.
// - Invalid seek target sets bit 10 and rejects operation.
// - Write command under write protection sets bit 11.
// - Timing failure or early sector pulse sets bit 12, aborts at once.
// - No progress within three index pulses sets bit 13, clears go.
// - Hazard condition sets bit 14; persists while condition remains.
// - Read ECC failure sets bit 15, starts correction unless disabled.
// - Drive clear or bus init clears the fault bits.
// - Any fault bit rising sets attention, deferred during data transfer.
// - Exception asserted at correction completion, held through end-of-block.
module dfl_fault_flags #(
  parameter int DRIVE_UNIT = 0,
  parameter logic [31:0] FN_IMPL = dfl_pkg::FN_IMPL_MASK,
  parameter logic [9:0] MAX_CYL = dfl_pkg::MAX_CYLINDER,
  parameter logic [4:0] MAX_TRK = dfl_pkg::MAX_TRACK
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control bus register access
  input wire logic busInit,
  input wire logic [4:0] regSel,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] wrData,
  input wire logic ctlParity,
  output logic [15:0] rdData,
  output logic rdValid,
  // Drive state
  input wire logic operationActive,
  input wire logic transferActive,
  input wire logic writeActive,
  input wire logic readActive,
  input wire logic positioning,
  input wire logic writeProtect,
  input wire logic readHeaderAndData,
  input wire logic format16,
  input wire logic eccCorrectionDisable,
  input wire logic runLine,
  // Fault and progress events
  input wire logic writeCommandIssued,
  input wire logic dataParityFault,
  input wire logic endOfBlockPulse,
  input wire logic headerVerify,
  input wire logic headerFormatBit,
  input wire logic offsetFormatBit,
  input wire logic headerAddrMismatch,
  input wire logic headerCheckFault,
  input wire logic writeClockMissing,
  input wire logic eccUncorrectable,
  input wire logic eccCheckFail,
  input wire logic eccCorrectionDone,
  input wire logic lastSectorDone,
  input wire logic seekStart,
  input wire logic [9:0] targetCylinder,
  input wire logic [4:0] targetTrack,
  input wire logic [4:0] targetSector,
  input wire logic timingFault,
  input wire logic sectorPulseRise,
  input wire logic dataInFlight,
  input wire logic searchStart,
  input wire logic searchProgress,
  input wire logic indexPulse,
  input wire logic hazardCondition,
  input wire logic positionDone,
  input wire logic startupDone,
  input wire logic availabilityNotice,
  input wire logic switchedFromNeutral,
  // Outputs to the drive and the controller
  output logic attentionLine,
  output logic exceptionLine,
  output logic compositeError,
  output logic [15:0] faultFlags,
  output logic abortCommand,
  output logic terminateCommand,
  output logic rejectOperation,
  output logic clearGo,
  output logic transferBlocked,
  output logic eccCorrectStart,
  output logic sectorContinue
);
  generate
    if (DRIVE_UNIT < 0 || DRIVE_UNIT > 7) begin : gBadUnit
      $error("dfl_fault_flags: DRIVE_UNIT must lie in 0 to 7");
    end
    // Without the drive clear code only bus init or a fault register write could clear the fault bits.
    if (!FN_IMPL[dfl_pkg::FN_DRIVE_CLEAR]) begin : gNoClear
      $error("dfl_fault_flags: FN_IMPL must include the drive clear code");
    end
  endgenerate

  // Register decode.
  wire logic selControl = regSel == dfl_pkg::SEL_CONTROL;
  wire logic selStatus = regSel == dfl_pkg::SEL_STATUS;
  wire logic selFault = regSel == dfl_pkg::SEL_FAULT_ONE;
  wire logic selMaint = regSel == dfl_pkg::SEL_MAINT;
  wire logic selSummary = regSel == dfl_pkg::SEL_ATTN_SUMMARY;
  wire logic selExists = dfl_pkg::SEL_EXIST_MASK[regSel];
  wire logic selReadOnly = dfl_pkg::SEL_READONLY_MASK[regSel];
  wire logic anyAccess = regWrite || regRead;

  // Odd parity across data and parity bit; an even count is a fault.
  wire logic ctlParityBad = regWrite && !(^{wrData, ctlParity});
  wire logic badSelect = anyAccess && !selExists;
  // Only maintenance and summary writes pass while a command runs.
  // A read-only write stays silent even while a command runs.
  wire logic refusedWrite = regWrite && selExists && operationActive
                            && !selMaint && !selSummary && !selReadOnly;
  // Read-only writes are dropped without any flag.
  wire logic writeOk = regWrite && selExists && !selReadOnly
                       && !refusedWrite && !ctlParityBad;

  // Control register command decode.
  wire logic [4:0] fnCode = wrData[dfl_pkg::CTL_FN_LSB +: dfl_pkg::CTL_FN_W];
  wire logic ctlWrite = writeOk && selControl;
  wire logic fnIllegal = ctlWrite && !FN_IMPL[fnCode];
  wire logic driveClear = ctlWrite && wrData[dfl_pkg::CTL_GO_BIT]
                          && (fnCode == dfl_pkg::FN_DRIVE_CLEAR) && !fnIllegal;
  wire logic clearFlags = driveClear || busInit;
  wire logic summaryClear = writeOk && selSummary && wrData[DRIVE_UNIT];

  // Seek target check, sector limit follows the pack format.
  wire logic [4:0] sectorLimit = format16 ? dfl_pkg::MAX_SECTOR_22 : dfl_pkg::MAX_SECTOR_20;
  wire logic targetBad = (targetSector > sectorLimit) || (targetCylinder > MAX_CYL)
                         || (targetTrack > MAX_TRK);
  wire logic invalidTarget = seekStart && targetBad;

  // Fault conditions from the drive.
  wire logic writeParity = dataParityFault && writeActive;
  wire logic formatMismatch = headerVerify && (headerFormatBit != offsetFormatBit);
  wire logic clockMissing = writeClockMissing && writeActive;
  wire logic overflow = lastSectorDone && runLine;
  wire logic protectHit = writeCommandIssued && writeProtect;
  wire logic timingHit = timingFault || (sectorPulseRise && dataInFlight);
  wire logic readEccHit = eccCheckFail && readActive;
  wire logic stallHit;

  wire logic [15:0] faultSet;
  wire logic [15:0] faultRising;
  wire logic [15:0] faultValue;
  wire logic faultLoad = writeOk && selFault;

  assign faultSet[dfl_pkg::FB_ILLEGAL_FUNCTION] = fnIllegal;
  assign faultSet[dfl_pkg::FB_BAD_REGISTER_SELECT] = badSelect;
  assign faultSet[dfl_pkg::FB_WRITE_REFUSED] = refusedWrite;
  assign faultSet[dfl_pkg::FB_ODD_CHECK_FAULT] = writeParity || ctlParityBad;
  assign faultSet[dfl_pkg::FB_PACK_FORMAT_MISMATCH] = formatMismatch;
  assign faultSet[dfl_pkg::FB_WRITE_CLOCK_MISSING] = clockMissing;
  assign faultSet[dfl_pkg::FB_UNCORRECTABLE_ECC] = eccUncorrectable;
  assign faultSet[dfl_pkg::FB_HEADER_MISMATCH] = headerAddrMismatch;
  assign faultSet[dfl_pkg::FB_HEADER_CHECK_FAULT] = headerCheckFault;
  assign faultSet[dfl_pkg::FB_ADDRESS_OVERFLOW] = overflow;
  assign faultSet[dfl_pkg::FB_INVALID_TARGET] = invalidTarget;
  assign faultSet[dfl_pkg::FB_WRITE_PROTECT_VIOLATION] = protectHit;
  assign faultSet[dfl_pkg::FB_TIMING_FAILURE] = timingHit;
  assign faultSet[dfl_pkg::FB_OPERATION_TIMEOUT] = stallHit;
  // A level, not a pulse: while the hazard remains, the bit sets again in the cycle after a drive clear.
  assign faultSet[dfl_pkg::FB_HAZARD_CONDITION] = hazardCondition;
  assign faultSet[dfl_pkg::FB_READ_ECC_FAULT] = readEccHit;

  dfl_sticky_bits #(
    .WIDTH(16),
    .RESET_VALUE(dfl_pkg::FAULT_RESET)
  ) uFault (
    .mclk(mclk),
    .rst_n(rst_n),
    .setBits(faultSet),
    .clearAll(clearFlags),
    .load(faultLoad),
    .loadValue(wrData),
    .flags(faultValue),
    .rising(faultRising)
  );

  dfl_stall_watch #(
    .LIMIT(dfl_pkg::STALL_INDEX_COUNT)
  ) uStall (
    .mclk(mclk),
    .rst_n(rst_n),
    .arm(searchStart),
    .progress(searchProgress),
    .abandon(clearFlags),
    .positioning(positioning),
    .indexPulse(indexPulse),
    .expired(stallHit)
  );

  // End-of-block trailing edge detection.
  logic eobPrev_reg;
  logic xferPrev_reg;
  wire logic eobFall = eobPrev_reg && !endOfBlockPulse;
  wire logic xferEnd = xferPrev_reg && !transferActive;

  // Parity fault follow-up and attention bookkeeping.
  logic parPending_reg;
  logic parPending_next;
  logic attnDeferred_reg;
  logic attnDeferred_next;
  wire logic anyRise = |faultRising;
  wire logic parTerminate = parPending_reg && eobFall && !runLine;
  wire logic parContinue = parPending_reg && eobFall && runLine;
  // Errors during a transfer wait for its end before raising attention.
  wire logic attnNow = (anyRise && !transferActive) || (xferEnd && attnDeferred_reg)
                       || parTerminate;
  // Availability seen right after leaving the neutral position is not announced.
  wire logic otherAttn = positionDone || startupDone
                         || (availabilityNotice && !switchedFromNeutral);
  wire logic attnClear = driveClear || summaryClear || busInit;

  always_comb begin
    parPending_next = parPending_reg;
    if (clearFlags || eobFall) begin
      parPending_next = 1'b0;
    end
    if (writeParity && !clearFlags) begin
      parPending_next = 1'b1;
    end
  end

  always_comb begin
    attnDeferred_next = attnDeferred_reg;
    if (attnClear || xferEnd) begin
      attnDeferred_next = 1'b0;
    end
    if ((anyRise || parContinue) && transferActive && !attnClear) begin
      attnDeferred_next = 1'b1;
    end
  end

  // Attention, exception and composite error flags.
  logic attention_reg;
  logic attention_next;
  logic exception_reg;
  logic exception_next;
  logic composite_reg;
  logic composite_next;

  assign attention_next = attnClear ? 1'b0 : (attention_reg || attnNow || otherAttn);
  // The trailing edge of end-of-block releases the line in both outcomes.
  assign exception_next = (eobFall || clearFlags) ? 1'b0
                          : (exception_reg || writeParity || eccCorrectionDone);
  assign composite_next = clearFlags ? 1'b0 : (composite_reg || anyRise);

  // Command actions.
  wire logic abortNow = (formatMismatch && !readHeaderAndData) || clockMissing
                        || timingHit;
  wire logic terminateNow = overflow || parTerminate;
  wire logic blockNow = (faultValue[dfl_pkg::FB_HEADER_MISMATCH]
                        || faultValue[dfl_pkg::FB_HEADER_CHECK_FAULT])
                        && !readHeaderAndData;
  wire logic continueNow = eobFall && runLine;
  wire logic correctNow = readEccHit && !eccCorrectionDisable;

  // Read data mux.
  wire logic [15:0] statusWord = {attention_reg, composite_reg, 14'h0000};
  wire logic [15:0] summaryWord = 16'(attention_reg) << DRIVE_UNIT;
  wire logic [15:0] readWord = selFault ? faultValue
                             : selStatus ? statusWord
                             : selSummary ? summaryWord
                             : 16'h0000;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      eobPrev_reg <= 1'b0;
      xferPrev_reg <= 1'b0;
      parPending_reg <= 1'b0;
      attnDeferred_reg <= 1'b0;
    end else begin
      eobPrev_reg <= endOfBlockPulse;
      xferPrev_reg <= transferActive;
      parPending_reg <= parPending_next;
      attnDeferred_reg <= attnDeferred_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      attention_reg <= 1'b0;
      exception_reg <= 1'b0;
      composite_reg <= 1'b0;
    end else begin
      attention_reg <= attention_next;
      exception_reg <= exception_next;
      composite_reg <= composite_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      abortCommand <= 1'b0;
      terminateCommand <= 1'b0;
      rejectOperation <= 1'b0;
      clearGo <= 1'b0;
      transferBlocked <= 1'b0;
      eccCorrectStart <= 1'b0;
      sectorContinue <= 1'b0;
    end else begin
      abortCommand <= abortNow;
      terminateCommand <= terminateNow;
      rejectOperation <= invalidTarget;
      clearGo <= stallHit;
      transferBlocked <= blockNow;
      eccCorrectStart <= correctNow;
      sectorContinue <= continueNow;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= regRead && selExists;
      if (regRead) begin
        rdData <= readWord;
      end
    end
  end

  assign attentionLine = attention_reg;
  assign exceptionLine = exception_reg;
  assign compositeError = composite_reg;
  assign faultFlags = faultValue;
endmodule

//--- sim/dfl_ctl_model.sv
// Controller-side model that issues register reads, writes and bus init.
module dfl_ctl_model (
  // Clock
  input wire logic mclk,
  // Register bus
  output logic busInit,
  output logic [4:0] regSel,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] wrData,
  output logic ctlParity,
  input wire logic [15:0] rdData,
  input wire logic rdValid
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    busInit = 1'h0;
    regSel = 5'h00;
    regWrite = 1'h0;
    regRead = 1'h0;
    wrData = 16'h0000;
    ctlParity = 1'h1;
  end
  // Parity is odd over data and parity bit; bad flips it on purpose.
  task automatic wr(input logic [4:0] s, input logic [15:0] d, input logic bad);
    @(negedge mclk);
    regSel = s;
    wrData = d;
    ctlParity = ~^d ^ bad;
    regWrite = 1'h1;
    @(negedge mclk);
    regWrite = 1'h0;
    // A released data bus shows the inverse, never the stale word.
    wrData = ~d;
  endtask
  task automatic rd(input logic [4:0] s, output logic [15:0] d, output logic v);
    @(negedge mclk);
    regSel = s;
    regRead = 1'h1;
    @(negedge mclk);
    regRead = 1'h0;
    d = rdData;
    v = rdValid;
  endtask
  task automatic init;
    @(negedge mclk);
    busInit = 1'h1;
    @(negedge mclk);
    busInit = 1'h0;
  endtask
endmodule

//--- sim/dfl_fault_flags_props.sv
// Concurrent checks on the ports of the drive error-flag logic.
module dfl_fault_flags_props #(
  parameter int DRIVE_UNIT = 0
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register bus
  input wire logic busInit,
  input wire logic [4:0] regSel,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] wrData,
  input wire logic ctlParity,
  input wire logic rdValid,
  // Drive state and events
  input wire logic operationActive,
  input wire logic transferActive,
  input wire logic endOfBlockPulse,
  // Outputs
  input wire logic attentionLine,
  input wire logic exceptionLine,
  input wire logic compositeError,
  input wire logic [15:0] faultFlags,
  input wire logic clearGo
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  wire wrGood = regWrite && ^{wrData, ctlParity} && !busInit;
  init_clear_a: assert property (busInit |=> faultFlags == 16'h0000 && !attentionLine
    && !compositeError && !exceptionLine) else $error("bus init left state set");
  illegal_fn_a: assert property (wrGood && regSel == dfl_pkg::SEL_CONTROL && !operationActive
    && !dfl_pkg::FN_IMPL_MASK[wrData[5:1]] |=> faultFlags[0]) else $error("bad function missed");
  bad_select_a: assert property (regRead && !busInit && !dfl_pkg::SEL_EXIST_MASK[regSel]
    |=> faultFlags[1] && !rdValid) else $error("bad select missed");
  write_refused_a: assert property (wrGood && operationActive
    && dfl_pkg::SEL_EXIST_MASK[regSel] && !dfl_pkg::SEL_READONLY_MASK[regSel]
    && regSel != dfl_pkg::SEL_MAINT && regSel != dfl_pkg::SEL_ATTN_SUMMARY
    |=> faultFlags[2]) else $error("refused write not flagged");
  eob_release_a: assert property ($fell(endOfBlockPulse) |-> ##[1:2] !exceptionLine)
    else $error("exception held past block end");
  fault_attn_a: assert property (|(faultFlags & ~$past(faultFlags)) && !$past(transferActive)
    && !$past(regWrite) |-> attentionLine) else $error("new fault without attention");
  fault_comp_a: assert property (|(faultFlags & ~$past(faultFlags)) |-> compositeError)
    else $error("new fault without composite error");
  summary_clear_a: assert property (wrGood && regSel == dfl_pkg::SEL_ATTN_SUMMARY
    && wrData[DRIVE_UNIT] |=> !attentionLine) else $error("summary write kept attention");
  sticky_bits_a: assert property (|($past(faultFlags) & ~faultFlags)
    |-> $past(busInit) || $past(regWrite)) else $error("fault bit dropped on its own");
  stall_go_a: assert property (clearGo |-> faultFlags[13])
    else $error("go cleared without stall flag");
  cover property (busInit);
  cover property ($fell(endOfBlockPulse) && exceptionLine);
  cover property (clearGo);
endmodule
bind dfl_fault_flags dfl_fault_flags_props #(.DRIVE_UNIT(DRIVE_UNIT))
  dfl_fault_flags_props_inst (.*);

//--- sim/disk_drive_error_flag_logic_tb_top.sv
// Self-checking bench for the drive error-flag logic.
module disk_drive_error_flag_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic rst_n = 1'h0;
  logic busInit, regWrite, regRead, ctlParity, rdValid, v;
  logic [4:0] regSel;
  logic [15:0] wrData, rdData, faultFlags, rd;
  logic operationActive = 1'h0, transferActive = 1'h0, writeActive = 1'h0;
  logic readActive = 1'h0, positioning = 1'h0, writeProtect = 1'h0, format16 = 1'h0;
  logic readHeaderAndData = 1'h0, eccCorrectionDisable = 1'h0, runLine = 1'h0;
  logic endOfBlockPulse = 1'h0, headerFormatBit = 1'h0, offsetFormatBit = 1'h0;
  logic dataInFlight = 1'h0, switchedFromNeutral = 1'h0;
  logic [9:0] targetCylinder = 10'h000;
  logic [4:0] targetTrack = 5'h00, targetSector = 5'h00;
  logic [19:0] evv = 20'h00000;
  wire headerVerify = evv[0], writeClockMissing = evv[1], eccUncorrectable = evv[2];
  wire headerAddrMismatch = evv[3], headerCheckFault = evv[4], lastSectorDone = evv[5];
  wire seekStart = evv[6], writeCommandIssued = evv[7], timingFault = evv[8];
  wire hazardCondition = evv[9], eccCheckFail = evv[10], sectorPulseRise = evv[11];
  wire dataParityFault = evv[12], eccCorrectionDone = evv[13], indexPulse = evv[14];
  wire searchStart = evv[15], positionDone = evv[16], startupDone = evv[17];
  wire availabilityNotice = evv[18], searchProgress = evv[19];
  logic attentionLine, exceptionLine, compositeError, abortCommand, terminateCommand;
  logic rejectOperation, clearGo, transferBlocked, eccCorrectStart, sectorContinue;
  wire [15:0] sts = {attentionLine, compositeError, exceptionLine, 13'h0000};
  int bad_count = 0, checked = 0, seed = 32'h5203, e;
  int fb[12] = '{4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 15, 12};
  int q[$];
  logic [3:0] act;
  int ex[12] = '{16, 16, 0, 1, 1, 8, 4, 0, 16, 0, 2, 16};
  dfl_fault_flags dfl_fault_flags_inst (.*);
  dfl_ctl_model dfl_ctl_model_inst (.*);
  always #25 mclk = ~mclk;
  task chk(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task w(input logic [4:0] s, input logic [15:0] d, input logic b = 1'h0);
    dfl_ctl_model_inst.wr(s, d, b);
  endtask
  task r(input logic [4:0] s);
    dfl_ctl_model_inst.rd(s, rd, v);
  endtask
  // Drive clear is the go bit with the clear function code.
  task dclr;
    w(dfl_pkg::SEL_CONTROL, ({11'h000, dfl_pkg::FN_DRIVE_CLEAR} << 1) | 16'h0001);
  endtask
  task pulse(input logic [19:0] m);
    @(negedge mclk);
    evv = m;
    @(negedge mclk);
    evv = 20'h00000;
    act = {abortCommand, terminateCommand, rejectOperation, eccCorrectStart};
  endtask
  task eob(input logic [15:0] want, input logic [1:0] wa);
    endOfBlockPulse = 1'h1;
    repeat (2) @(negedge mclk);
    endOfBlockPulse = 1'h0;
    @(negedge mclk);
    chk({terminateCommand, sectorContinue}, wa);
    repeat (2) @(negedge mclk);
    chk(sts, want);
  endtask
  task end_of_test;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (4) @(negedge mclk);
    rst_n = 1'h1;
    chk(faultFlags | sts, dfl_pkg::FAULT_RESET);
    w(dfl_pkg::SEL_CONTROL, 16'h000A);
    chk(faultFlags, {15'h0000, ~dfl_pkg::FN_IMPL_MASK[5]});
    chk(sts, 16'hC000);
    dclr;
    chk(faultFlags | sts, 16'h0000);
    r(5'h10);
    chk({rd[15:1], v}, 16'h0000);
    w(dfl_pkg::SEL_STATUS, 16'hFFFF);
    chk(faultFlags, 16'h0002);
    operationActive = 1'h1;
    // A drive clear during an operation is refused like other control register writes.
    dclr;
    w(dfl_pkg::SEL_MAINT, 16'h1234);
    chk(faultFlags, 16'h0006);
    operationActive = 1'h0;
    w(dfl_pkg::SEL_MAINT, 16'h0000, 1'h1);
    chk(faultFlags, 16'h000E);
    dfl_ctl_model_inst.init;
    chk(faultFlags | sts, 16'h0000);
    $display("test register access done");
    repeat (3) begin
      rd = 16'($random(seed));
      q.push_back(rd);
      w(dfl_pkg::SEL_FAULT_ONE, rd);
      r(dfl_pkg::SEL_FAULT_ONE);
      e = q.pop_front();
      chk(rd, e[15:0]);
      chk({15'h0000, v}, 16'h0001);
      chk(sts, e != 0 ? 16'hC000 : 16'h0000);
      dfl_ctl_model_inst.init;
    end
    $display("test diagnostic write done");
    writeActive = 1'h1;
    readActive = 1'h1;
    runLine = 1'h1;
    writeProtect = 1'h1;
    dataInFlight = 1'h1;
    headerFormatBit = 1'h1;
    for (int i = 0; i < 12; i++) begin
      targetCylinder = 10'($unsigned($random(seed)) % (dfl_pkg::MAX_CYLINDER + 1));
      targetTrack = 5'($unsigned($random(seed)) % (dfl_pkg::MAX_TRACK + 1));
      targetSector = 5'h14 + 5'($unsigned($random(seed)) % 12);
      dclr;
      pulse(20'h00001 << i);
      @(negedge mclk);
      chk(faultFlags, 16'h0001 << fb[i]);
      chk(sts, 16'hC000);
      chk({act, transferBlocked}, 16'(ex[i]));
    end
    format16 = 1'h1;
    targetSector = dfl_pkg::MAX_SECTOR_22;
    dclr;
    pulse(20'h00040);
    chk(faultFlags, 16'h0000);
    $display("test fault events done");
    pulse(20'h08000);
    pulse(20'h04000);
    pulse(20'h04000);
    chk(faultFlags, 16'h0000);
    pulse(20'h04000);
    @(negedge mclk);
    chk(faultFlags | {15'h0000, clearGo}, 16'h2001);
    dclr;
    transferActive = 1'h1;
    runLine = 1'h0;
    pulse(20'h01000);
    chk(faultFlags | sts, 16'h6008);
    eob(16'hC000, 2'h2);
    pulse(20'h02000);
    chk(sts & 16'h2000, 16'h2000);
    runLine = 1'h1;
    eob(16'hC000, 2'h1);
    $display("test block end done");
    transferActive = 1'h0;
    dfl_ctl_model_inst.init;
    switchedFromNeutral = 1'h1;
    pulse(20'h40000);
    chk(sts, 16'h0000);
    pulse(20'h30000);
    chk(sts & 16'h8000, 16'h8000);
    w(dfl_pkg::SEL_ATTN_SUMMARY, 16'h0001);
    chk(sts & 16'h8000, 16'h0000);
    $display("test attention done");
    end_of_test;
  end
endmodule
